// file: bench/i2c_quasi_bidir_io_expander_bench.sv
`timescale 1ns/1ps
`default_nettype none
module i2c_quasi_bidir_io_expander_bench;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [2:0] straps = 3'h5;
    logic [7:0] ext = 8'hff;
    logic scl, sda_drv, sda_oe_n, alert_oe_n;
    logic [7:0] pins_low, pins_strong;
    logic [8:0] r;
    int miscompares = 0;
    int cmp_count = 0;
    wire logic sda_bus = sda_drv & sda_oe_n;
    wire logic [7:0] pins = ext & ~pins_low;
    always #50 clk_sys = ~clk_sys;
    qbx_expander i_dut (.clk_sys(clk_sys), .rst(rst), .scl_in(scl), .sda_in(sda_bus),
        .sda_oe_n(sda_oe_n), .addr_strap_pins(straps), .expander_pins_in(pins),
        .expander_pins_low(pins_low), .expander_pins_strong(pins_strong),
        .alert_oe_n(alert_oe_n));
    qbx_ctl_model i_ctl (.clk_sys(clk_sys), .sda_bus(sda_bus), .scl(scl), .sda_drv(sda_drv));
    // ****
    // helpers
    // ****
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wclk(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_ctl.cond(1'b1);
        i_ctl.xb({a, 1'b1}, 9, r);
        i_ctl.xb({d, 1'b1}, 9, r);
        i_ctl.cond(1'b0);
    endtask
    task automatic pins_to(input logic [7:0] v);
        ext <= v;
        wclk(40);
    endtask
    task automatic t_addr();
        logic [7:0] a [3];
        a = '{8'h7a, 8'h78, 8'h00};
        for (int i = 0; i < 3; i++)
        begin
            i_ctl.cond(1'b1);
            i_ctl.xb({a[i], 1'b1}, 9, r);
            i_ctl.cond(1'b0);
            chk("addr ack", {7'h00, r[0]}, {7'h00, i != 0});
        end
        straps <= 3'h2;
        ext <= 8'h96;
        wclk(40);
        i_ctl.cond(1'b1);
        i_ctl.xb({8'h75, 1'b1}, 9, r);
        chk("strap ack", {7'h00, r[0]}, 8'h00);
        i_ctl.xb(9'h1fe, 9, r);
        chk("read one", r[8:1], 8'h96);
        i_ctl.xb(9'h1ff, 9, r);
        chk("read two", r[8:1], 8'h96);
        i_ctl.cond(1'b0);
        straps <= 3'h5;
        ext <= 8'hff;
        wclk(40);
        $display("address test done");
    endtask
    task automatic t_write();
        i_ctl.cond(1'b1);
        i_ctl.xb({8'h7a, 1'b1}, 9, r);
        i_ctl.xb({8'ha5, 1'b1}, 9, r);
        chk("data ack", {7'h00, r[0]}, 8'h00);
        i_ctl.xb({8'h00, 1'b1}, 9, r);
        chk("pattern", pins_low, 8'h5a);
        i_ctl.cond(1'b1);
        i_ctl.xb({8'h7a, 1'b1}, 9, r);
        i_ctl.xb({8'hff, 1'b1}, 9, r);
        chk("boost", pins_strong, 8'h5a);
        i_ctl.cond(1'b1);
        chk("boost end", pins_strong, 8'h00);
        i_ctl.xb({8'h7a, 1'b1}, 9, r);
        i_ctl.xb({8'h00, 1'b1}, 4, r);
        i_ctl.cond(1'b0);
        chk("partial", pins_low, 8'h00);
        $display("write test done");
    endtask
    task automatic t_alert();
        wr(8'h7a, 8'hf0);
        pins_to(8'h7f);
        chk("alert", {7'h00, alert_oe_n}, 8'h00);
        i_ctl.cond(1'b1);
        i_ctl.xb({8'h7b, 1'b1}, 9, r);
        i_ctl.xb(9'h1ff, 9, r);
        i_ctl.cond(1'b0);
        chk("read", r[8:1], 8'h70);
        chk("read clear", {7'h00, alert_oe_n}, 8'h01);
        pins_to(8'hff);
        chk("alert again", {7'h00, alert_oe_n}, 8'h00);
        pins_to(8'h7f);
        chk("alert back", {7'h00, alert_oe_n}, 8'h01);
        pins_to(8'hff);
        wr(8'h70, 8'h00);
        chk("other target", {7'h00, alert_oe_n}, 8'h00);
        wr(8'h7a, 8'hf0);
        chk("write clear", {7'h00, alert_oe_n}, 8'h01);
        $display("alert test done");
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial
    begin
        wclk(8);
        rst <= 1'b0;
        wclk(12);
        chk("reset drive", pins_low | pins_strong, 8'h00);
        chk("reset lines", {6'h00, alert_oe_n, sda_oe_n}, 8'h03);
        t_addr();
        t_write();
        t_alert();
        conclude();
    end
    initial
    begin
        #5000000;
        miscompares++;
        conclude();
    end
endmodule
bind qbx_expander qbx_chk i_chk (.clk_sys(clk_sys), .rst(rst), .scl_in(scl_in),
    .sda_in(sda_in), .sda_oe_n(sda_oe_n), .addr_strap_pins(addr_strap_pins),
    .expander_pins_in(expander_pins_in), .expander_pins_low(expander_pins_low),
    .expander_pins_strong(expander_pins_strong), .alert_oe_n(alert_oe_n));
`default_nettype wire

// file: bench/qbx_chk_sva.sv
`timescale 1ns/1ps
`default_nettype none
module qbx_chk (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_oe_n,
    input wire logic [2:0] addr_strap_pins,
    input wire logic [7:0] expander_pins_in,
    input wire logic [7:0] expander_pins_low,
    input wire logic [7:0] expander_pins_strong,
    input wire logic alert_oe_n
);
    // ****
    // cycles since the last pin change
    // ****
    logic [7:0] prev;
    logic [4:0] age;
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            prev <= 8'hff;
            age <= 5'h1f;
        end
        else
        begin
            prev <= expander_pins_in;
            if (expander_pins_in != prev)
                age <= 5'h00;
            else if (age != 5'h1f)
                age <= age + 5'h01;
        end
    end
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    sequence s_boost_off;
        ##[1:12] (expander_pins_strong == 8'h00);
    endsequence
    reset_state_a: assert property ($fell(rst) |-> expander_pins_low == 8'h00 &&
        expander_pins_strong == 8'h00 && alert_oe_n && sda_oe_n) else $error("not idle");
    boost_pull_a: assert property ((expander_pins_strong & expander_pins_low) == 8'h00)
        else $error("boost against pull-down");
    boost_end_a: assert property ($fell(scl_in) |-> s_boost_off)
        else $error("boost outlived clock fall");
    sda_move_a: assert property ($changed(sda_oe_n) |-> !scl_in)
        else $error("data moved with clock high");
    ack_hold_a: assert property ($rose(scl_in) && !sda_oe_n |-> !sda_oe_n [*8])
        else $error("data low not held");
    latch_time_a: assert property ($changed(expander_pins_low) |-> scl_in)
        else $error("latch moved with clock low");
    alert_cause_a: assert property ($fell(alert_oe_n) |-> age <= 5'h0e)
        else $error("alert without pin change");
    alert_clear_a: assert property ($rose(alert_oe_n) |-> age <= 5'h0e || scl_in)
        else $error("alert cleared without cause");
endmodule
`default_nettype wire

// file: bench/qbx_ctl_model.sv
`timescale 1ns/1ps
`default_nettype none
module qbx_ctl_model #(
    parameter int H = 10
) (
    input wire logic clk_sys,
    input wire logic sda_bus,
    output logic scl,
    output logic sda_drv
);
    // ****
    // bus controller, data released means pulled high
    // ****
    initial scl = 1'b1;
    initial sda_drv = 1'b1;
    task automatic hw();
        repeat (H) @(posedge clk_sys);
    endtask
    task automatic bitx(input logic d, output logic q);
        scl <= 1'b0;
        hw();
        sda_drv <= d;
        hw();
        scl <= 1'b1;
        hw();
        q = sda_bus;
        hw();
    endtask
    // data moves with clock high: 1 makes a start, 0 a stop
    task automatic cond(input logic d);
        logic q;
        bitx(d, q);
        sda_drv <= !d;
        hw();
    endtask
    task automatic xb(input logic [8:0] b, input int n, output logic [8:0] r);
        r = 9'h1ff;
        for (int i = 8; i > 8 - n; i--)
            bitx(b[i], r[i]);
    endtask
endmodule
`default_nettype wire

// file: design/qbx_expander.v
`timescale 1ns/1ps
`default_nettype none
`include "qbx_regs.vh"

// What this block does
// [RQ1] after reset all pins rest high, weak source only, no strong drive
// [RQ2] writing a one pulses the strong pull-up until the next bus clock fall; the code pulses it only on pins whose latch goes from 0 to 1
// [RQ3] controller writes one to a pin before using it as input
// [RQ4] alert is open-drain, pulls low, needs no bus transaction
// [RQ5] any rising or falling pin edge asserts the alert; the code watches only pins latched high
// [RQ6] alert clears when pins return to captured levels or on port access
// [RQ7] access clears alert at the acknowledge bit clock
// [RQ8] pin changes in the acknowledge pulse may be lost or brief
// [RQ9] after clearing, every later change shows after next bus clock rise; the code raises the alert once a change lasts two system clocks
// [RQ10] transactions for other targets leave alert logic untouched
// [RQ11] start is data fall with clock high, stop is data rise with clock high
// [RQ12] address msb first: 0111, strap bits, then direction bit
// [RQ13] answers even write and odd read addresses set by straps
// [RQ14] never answers the general call address
// [RQ15] acknowledges a match by holding data low through ninth clock high
// [RQ16] straps stay stable from start to stop
// [RQ17] read returns pin levels, bit 7 is highest pin
// [RQ18] first written byte becomes the pin pattern, bit for bit
// [RQ19] first data byte acknowledged, later bytes ignored
// [RQ20] latches change only after a full acknowledged byte
// [RQ21] stop mid-transfer keeps last latched value, drops partial byte
// [RQ22] reset returns bus logic to idle and pins high
// [RQ23] bus lines and pins synchronised and filtered before edge detection
module qbx_expander #(
    parameter WIDTH = 8
) (
    input wire clk_sys,
    input wire rst,
    input wire scl_in,
    input wire sda_in,
    output reg sda_oe_n,
    input wire [2:0] addr_strap_pins,
    input wire [WIDTH-1:0] expander_pins_in,
    output reg [WIDTH-1:0] expander_pins_low,
    output reg [WIDTH-1:0] expander_pins_strong,
    output reg alert_oe_n
);

    // ************************************************************
    // synchronisers and glitch filters
    // ************************************************************
    localparam NS = WIDTH + 2;
    wire [NS-1:0] raw_in = {scl_in, sda_in, expander_pins_in};
    reg [NS-1:0] sync_a;
    reg [NS-1:0] sync_b;
    reg [NS-1:0] filt;
    reg [2:0] straps;

    genvar gi;
    generate
        for (gi = 0; gi < NS; gi = gi + 1)
        begin : g_filt
            reg [`QBX_FILT_LEN-1:0] hist;
            always @(posedge clk_sys or posedge rst)
            begin
                if (rst)
                begin
                    sync_a[gi] <= 1'b1;
                    sync_b[gi] <= 1'b1;
                    hist <= {`QBX_FILT_LEN{1'b1}};
                    filt[gi] <= 1'b1;
                end
                else
                begin
                    sync_a[gi] <= raw_in[gi]; // RQ23
                    sync_b[gi] <= sync_a[gi];
                    hist <= {hist[`QBX_FILT_LEN-2:0], sync_b[gi]};
                    if (&hist)
                        filt[gi] <= 1'b1; // RQ23
                    else if (~|hist)
                        filt[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    reg [2:0] strap_a;
    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            strap_a <= 3'h0;
            straps <= 3'h0;
        end
        else
        begin
            strap_a <= addr_strap_pins;
            straps <= strap_a;
        end
    end

    wire scl = filt[NS-1];
    wire sda = filt[NS-2];
    wire [WIDTH-1:0] pins = filt[WIDTH-1:0];
    reg scl_d;
    reg sda_d;
    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end
        else
        begin
            scl_d <= scl;
            sda_d <= sda;
        end
    end
    wire scl_rise = scl & ~scl_d;
    wire scl_fall = ~scl & scl_d;
    wire start_det = scl & scl_d & sda_d & ~sda; // RQ11
    wire stop_det = scl & scl_d & ~sda_d & sda; // RQ11

    // ************************************************************
    // bus target state machine
    // ************************************************************
    localparam ST_IDLE = 3'h0;
    localparam ST_ADDR = 3'h1;
    localparam ST_WDATA = 3'h2;
    localparam ST_RDATA = 3'h3;
    localparam ST_IGNORE = 3'h4;

    reg [2:0] state;
    reg [3:0] bit_cnt;
    reg [7:0] shift;
    reg [7:0] tx_byte;
    reg rnw;
    reg wr_done;
    reg ack_phase;
    reg acc_clear;
    reg [WIDTH-1:0] port_latch;

    wire addr_match = (shift[7:4] == `QBX_ADDR_FIXED) && (shift[3:1] == straps); // RQ12 RQ13 RQ14

    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            state <= ST_IDLE; // RQ22
            bit_cnt <= 4'h0;
            shift <= 8'h00;
            tx_byte <= 8'h00;
            rnw <= 1'b0;
            wr_done <= 1'b0;
            ack_phase <= 1'b0;
            acc_clear <= 1'b0;
            sda_oe_n <= 1'b1;
            port_latch <= `QBX_PORT_RESET; // RQ1 RQ22
            expander_pins_strong <= {WIDTH{1'b0}};
            expander_pins_low <= {WIDTH{1'b0}};
        end
        else
        begin
            acc_clear <= 1'b0;
            if (scl_fall)
                expander_pins_strong <= {WIDTH{1'b0}}; // RQ2
            if (start_det)
            begin
                state <= ST_ADDR;
                bit_cnt <= 4'h0;
                ack_phase <= 1'b0;
                sda_oe_n <= 1'b1;
            end
            else if (stop_det)
            begin
                state <= ST_IDLE; // RQ21
                ack_phase <= 1'b0;
                sda_oe_n <= 1'b1;
            end
            else
            begin
                case (state)
                    ST_IDLE:
                        sda_oe_n <= 1'b1;
                    ST_ADDR, ST_WDATA:
                    begin
                        if (scl_rise && !ack_phase)
                        begin
                            shift <= {shift[6:0], sda};
                            bit_cnt <= bit_cnt + 4'h1;
                        end
                        if (scl_fall && !ack_phase && bit_cnt == `QBX_BIT_ACK)
                        begin
                            ack_phase <= 1'b1;
                            if (state == ST_ADDR && addr_match)
                                sda_oe_n <= 1'b0; // RQ15
                            else if (state == ST_WDATA && !wr_done)
                                sda_oe_n <= 1'b0; // RQ19
                            else
                                state <= ST_IGNORE; // RQ10 RQ19
                        end
                        if (scl_rise && ack_phase && state == ST_WDATA)
                        begin
                            port_latch <= shift[WIDTH-1:0]; // RQ18 RQ20
                            // pull-down moves with the boost so both never meet on a pin
                            expander_pins_low <= ~shift[WIDTH-1:0]; // RQ1 RQ20
                            expander_pins_strong <= shift[WIDTH-1:0] & ~port_latch; // RQ2
                            wr_done <= 1'b1;
                            acc_clear <= 1'b1; // RQ7
                        end
                        if (scl_fall && ack_phase)
                        begin
                            ack_phase <= 1'b0;
                            bit_cnt <= 4'h0;
                            sda_oe_n <= 1'b1;
                            if (state == ST_ADDR)
                            begin
                                rnw <= shift[0];
                                wr_done <= 1'b0;
                                if (shift[0])
                                begin
                                    state <= ST_RDATA;
                                    tx_byte <= {pins[6:0], 1'b0};
                                    sda_oe_n <= pins[7]; // RQ17
                                end
                                else
                                    state <= ST_WDATA;
                            end
                        end
                    end
                    ST_RDATA:
                    begin
                        if (scl_rise)
                        begin
                            bit_cnt <= bit_cnt + 4'h1;
                            if (bit_cnt == `QBX_BIT_ACK)
                            begin
                                acc_clear <= 1'b1; // RQ7
                                if (sda)
                                    state <= ST_IGNORE;
                            end
                        end
                        if (scl_fall)
                        begin
                            if (bit_cnt == `QBX_BIT_ACK)
                                sda_oe_n <= 1'b1;
                            else if (bit_cnt == 4'h9)
                            begin
                                bit_cnt <= 4'h0;
                                tx_byte <= {pins[6:0], 1'b0};
                                sda_oe_n <= pins[7]; // RQ17
                            end
                            else
                            begin
                                sda_oe_n <= tx_byte[7];
                                tx_byte <= {tx_byte[6:0], 1'b0};
                            end
                        end
                    end
                    ST_IGNORE:
                        sda_oe_n <= 1'b1; // RQ10
                    default:
                        state <= ST_IDLE;
                endcase
            end
        end
    end

    // ************************************************************
    // pin change alert
    // ************************************************************
    reg [WIDTH-1:0] captured;
    reg alert;
    reg rise_pending;
    wire [WIDTH-1:0] in_use = port_latch; // RQ3
    wire changed = |((pins ^ captured) & in_use);

    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            captured <= `QBX_PORT_RESET;
            alert <= 1'b0;
            rise_pending <= 1'b0;
            alert_oe_n <= 1'b1;
        end
        else
        begin
            if (acc_clear)
            begin
                captured <= pins; // RQ6 RQ8
                alert <= 1'b0;
                rise_pending <= 1'b0;
            end
            else if (changed)
            begin
                rise_pending <= 1'b1; // RQ5 RQ9
                if (rise_pending || alert)
                    alert <= 1'b1;
            end
            else
            begin
                alert <= 1'b0; // RQ6
                rise_pending <= 1'b0;
            end
            alert_oe_n <= ~alert; // RQ4
        end
    end

endmodule
`default_nettype wire

// file: design/qbx_regs.vh
`ifndef QBX_REGS_VH
`define QBX_REGS_VH
// fixed upper address nibble, low high high high
`define QBX_ADDR_FIXED 4'h7
`define QBX_PORT_RESET 8'hff
`define QBX_FILT_LEN 3
`define QBX_BIT_LAST 4'h7
`define QBX_BIT_ACK 4'h8
`endif
